// [otl_pkg.sv]
// Package: register map, field layout and timing constants for the overtemp limit block.
// Assumes a 125 MHz mclk and an Avalon-MM slave with 32-bit data, byte addresses.
package otl_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_LIMIT = 8'h7a;
	localparam logic [7:0] IDX_PULSE = 8'h7b;
	localparam logic [7:0] IDX_ISTAT = 8'h42;
	localparam logic [7:0] IDX_TIMER = 8'h79;
	localparam logic [7:0] IDX_IEN = 8'h80;
	localparam logic [7:0] IDX_ICLR = 8'h81;
	localparam logic [7:0] IDX_CFG = 8'h82;
	localparam int ADDR_W = 10;
	// Reset values
	localparam logic [7:0] LIMIT_RST = 8'h00;
	localparam logic [7:0] PULSE_RST = 8'h55;
	localparam logic [1:0] PULSE_CODE_RST = 2'h1;
	// Status and config bit positions, field sizes
	localparam int ST_TIMER_BIT = 5;
	localparam int ST_ASSERT_BIT = 0;
	localparam int CFG_SHARED_BIT = 0;
	localparam int CFG_MASK_BIT = 1;
	localparam int PULSE_FIELD_W = 2;
	localparam int N_CHAN = 4;
	// Timing: one timer step in microseconds
	localparam int CLK_MHZ = 125;
	localparam int STEP_US = 22760;
	localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
	localparam logic [7:0] TIMER_MAX = 8'hff;
	localparam logic [7:0] TIMER_TWO = 8'h02;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [31:0] writedata;
	} otl_req_s;
endpackage : otl_pkg

// [otl_step_div.sv]
// Step divider: emits a one-cycle enable every step period while running.
// Assumes the caller restarts it at the start of each assertion.
`timescale 1ns/1ps
`default_nettype none
module otl_step_div #(
	parameter int unsigned PERIOD = 2845000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic run,
	output logic tick
);
	logic [31:0] cnt_q;

	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			cnt_q <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_q == 32'(PERIOD - 1)) begin
			cnt_q <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule : otl_step_div
`default_nettype wire

// [otl_top.sv]
// Overtemp assertion timer with duration limit, and fan pulse-count configuration.
// Assumes overtemp_pin is asynchronous, active high; Avalon-MM master on mclk.
// Contract
// R1: Software-writable limit on how long the overtemp input may stay asserted.
// R2: Limit is 8 bits, step 22.76 ms, spanning 45.52 ms to 5.82 s. A limit of 0xff never fires here, since the count saturates at 0xff.
// R3: Timer beyond limit sets bit 5 of interrupt status register 0x42.
// R4: Limit of zero raises the event as soon as input asserts.
// R5: Channel 1 pulse-count field, codes 00..11 count 1..4, resets to 01.
// R6: Channel 2 has own pulse-count field, same codes, resets to 01.
// R7: Channel 3 has own pulse-count field, same codes, resets to 01.
// R8: Channel 4 has own pulse-count field, same codes, resets to 01.
// R9: Software may step pulse count to find pulses per revolution.
// R10: Device times assertion; upper seven bits zero until 45.52 ms; 22.76 ms steps.
// R11: In shared mode the fan-4 mask bit gates the timer event alert.
// R12: Pulse fields packed two bits each, channel 1 at 1:0 to 7:6.
`timescale 1ns/1ps
`default_nettype none
module otl_top #(
	parameter int unsigned STEP_CYCLES = otl_pkg::STEP_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [otl_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Overtemp input
	input wire logic overtemp_pin,
	// Pulse-count selections to tach logic
	output logic [1:0] chan1_pulse_count,
	output logic [1:0] chan2_pulse_count,
	output logic [1:0] chan3_pulse_count,
	output logic [1:0] chan4_pulse_count,
	// Interrupt
	output logic irq
);
	otl_pkg::otl_req_s req;
	logic [7:0] assert_duration_limit_q;
	logic [7:0] pulse_q;
	logic [7:0] assert_duration_count_q;
	logic [7:0] istat_q;
	logic [7:0] ien_q;
	logic [1:0] cfg_q;
	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic tick;
	logic over_q;
	logic [7:0] set_ev;
	logic [7:0] clr_ev;
	logic ack_q;
	logic [7:0] word_idx;
	logic wr_hit;

	assign req.read = read;
	assign req.write = write;
	assign req.address = address;
	assign req.writedata = writedata;
	assign word_idx = req.address[otl_pkg::ADDR_W-1:2];
	assign wr_hit = req.write && ack_q;

	// Two-flop synchroniser for the pin
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			sync1_q <= overtemp_pin;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	otl_step_div #(
		.PERIOD(STEP_CYCLES)
	) u_div (
		.mclk(mclk),
		.rst(rst),
		.run(sync2_q),
		.tick(tick)
	);

	// Assertion timer restarts on each new assertion, holds after release
	always_ff @(posedge mclk) begin
		if (rst) begin
			assert_duration_count_q <= 8'h00;
		end else if (sync2_q && !prev_q) begin
			assert_duration_count_q <= 8'h00; // [R10]
		end else if (tick && assert_duration_count_q != otl_pkg::TIMER_MAX) begin
			assert_duration_count_q <= assert_duration_count_q + 8'h01; // [R10] [R2]
		end
	end

	// Upper bits read zero below two steps, where bit 0 flags assertion; from two steps on the count reads as is
	function automatic logic [7:0] timer_view(input logic [7:0] t, input logic asrt);
		logic [7:0] v;
		v = 8'h00;
		if (t >= otl_pkg::TIMER_TWO) begin
			v = t; // [R10]
		end else begin
			v[otl_pkg::ST_ASSERT_BIT] = asrt;
		end
		return v;
	endfunction : timer_view

	// Limit compare; zero limit fires on assertion alone
	always_ff @(posedge mclk) begin
		if (rst) begin
			over_q <= 1'b0;
		end else if (!sync2_q) begin
			over_q <= 1'b0;
		end else if (assert_duration_limit_q == otl_pkg::LIMIT_RST) begin
			over_q <= 1'b1; // [R4]
		end else begin
			// First cycle of a new assertion still sees the old, held count
			over_q <= prev_q && (assert_duration_count_q > assert_duration_limit_q); // [R3]
		end
	end

	always_comb begin
		set_ev = 8'h00;
		set_ev[otl_pkg::ST_TIMER_BIT] = over_q; // [R3]
		clr_ev = 8'h00;
		if (wr_hit && word_idx == otl_pkg::IDX_ICLR) begin
			clr_ev = req.writedata[7:0];
		end
	end

	// Sticky status: set wins over clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			istat_q <= 8'h00;
		end else begin
			istat_q <= (istat_q & ~clr_ev) | set_ev; // [R3]
		end
	end

	// Writable registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			assert_duration_limit_q <= otl_pkg::LIMIT_RST;
			pulse_q <= otl_pkg::PULSE_RST; // [R5] [R6] [R7] [R8]
			ien_q <= 8'h00;
			cfg_q <= 2'h0;
		end else if (wr_hit) begin
			unique case (word_idx)
				otl_pkg::IDX_LIMIT: assert_duration_limit_q <= req.writedata[7:0]; // [R1]
				otl_pkg::IDX_PULSE: pulse_q <= req.writedata[7:0]; // [R9]
				otl_pkg::IDX_IEN: ien_q <= req.writedata[7:0];
				otl_pkg::IDX_CFG: cfg_q <= req.writedata[1:0];
				default: ;
			endcase
		end
	end

	// Fields packed two bits per channel
	always_ff @(posedge mclk) begin
		if (rst) begin
			chan1_pulse_count <= otl_pkg::PULSE_CODE_RST;
			chan2_pulse_count <= otl_pkg::PULSE_CODE_RST;
			chan3_pulse_count <= otl_pkg::PULSE_CODE_RST;
			chan4_pulse_count <= otl_pkg::PULSE_CODE_RST;
		end else begin
			chan1_pulse_count <= pulse_q[1:0]; // [R12] [R5]
			chan2_pulse_count <= pulse_q[3:2]; // [R12] [R6]
			chan3_pulse_count <= pulse_q[5:4]; // [R12] [R7]
			chan4_pulse_count <= pulse_q[7:6]; // [R12] [R8]
		end
	end

	// Interrupt: shared mode lets the fan-4 mask bit also gate the timer event
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(istat_q & ien_q) &&
				!(cfg_q[otl_pkg::CFG_SHARED_BIT] && cfg_q[otl_pkg::CFG_MASK_BIT] &&
				!(|(istat_q & ien_q & ~(8'h01 << otl_pkg::ST_TIMER_BIT)))); // [R11]
		end
	end

	// One-wait-state slave: accept on second cycle of the request
	always_ff @(posedge mclk) begin
		if (rst) begin
			ack_q <= 1'b0;
			readdata <= 32'h0;
		end else begin
			ack_q <= (req.read || req.write) && !ack_q;
			if (req.read && !ack_q) begin
				unique case (word_idx)
					otl_pkg::IDX_LIMIT: readdata <= {24'h0, assert_duration_limit_q};
					otl_pkg::IDX_PULSE: readdata <= {24'h0, pulse_q};
					otl_pkg::IDX_ISTAT: readdata <= {24'h0, istat_q};
					otl_pkg::IDX_TIMER: readdata <= {24'h0,
						timer_view(assert_duration_count_q, sync2_q)};
					otl_pkg::IDX_IEN: readdata <= {24'h0, ien_q};
					otl_pkg::IDX_CFG: readdata <= {30'h0, cfg_q};
					default: readdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((req.read || req.write) && !ack_q);
		end
	end
endmodule : otl_top
`default_nettype wire

// [otl_checker.sv]
// Checker: bus answer, pulse fields, overtemp irq.
// Bound to otl_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module otl_checker #(
	parameter int unsigned STEP_CYCLES = 10
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Bus
	input wire logic [otl_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Overtemp and outputs
	input wire logic overtemp_pin,
	input wire logic [1:0] chan1_pulse_count,
	input wire logic [1:0] chan2_pulse_count,
	input wire logic [1:0] chan3_pulse_count,
	input wire logic [1:0] chan4_pulse_count,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [7:0] lim_q, en_q, cf_q, idx;
	logic wr;
	assign idx = address[9:2];
	assign wr = write & !waitrequest;
	// Shadows of writable registers
	always_ff @(posedge mclk) begin
		if (rst) lim_q <= 8'h00;
		else if (wr && idx == otl_pkg::IDX_LIMIT) lim_q <= writedata[7:0];
	end
	always_ff @(posedge mclk) begin
		if (rst) en_q <= 8'h00;
		else if (wr && idx == otl_pkg::IDX_IEN) en_q <= writedata[7:0];
	end
	always_ff @(posedge mclk) begin
		if (rst) cf_q <= 8'h00;
		else if (wr && idx == otl_pkg::IDX_CFG) cf_q <= writedata[7:0];
	end
	a_wait_one: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low twice");
	a_wait_answer: assert property ((read || write) && !$past(read || write) |-> ##[1:2] !waitrequest)
		else $error("request not answered");
	a_pulse_write: assert property (wr && idx == otl_pkg::IDX_PULSE |->
		##2 {chan4_pulse_count, chan3_pulse_count, chan2_pulse_count, chan1_pulse_count}
		== $past(writedata[7:0], 2)) else $error("pulse field wrong");
	a_pulse_cause: assert property (!$stable({chan4_pulse_count, chan3_pulse_count,
		chan2_pulse_count, chan1_pulse_count})
		|-> $past(wr && idx == otl_pkg::IDX_PULSE, 2)) else $error("pulse field moved");
	a_limit_read: assert property (read && !waitrequest && idx == otl_pkg::IDX_LIMIT
		|-> readdata == {24'h0, lim_q}) else $error("limit readback wrong");
	a_unmapped_zero: assert property (read && !waitrequest && idx < 8'h42
		|-> readdata == 32'h0) else $error("unmapped read nonzero");
	a_zero_limit: assert property (lim_q == 8'h00 && en_q[5] && cf_q[1:0] != 2'h3
		&& $rose(overtemp_pin) |-> ##[1:8] irq) else $error("zero limit no irq");
	a_irq_masked: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 |=> !irq)
		else $error("irq while disabled");
endmodule : otl_checker
bind otl_top otl_checker #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.mclk(mclk), .rst(rst),
	.address(address), .read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .overtemp_pin(overtemp_pin),
	.chan1_pulse_count(chan1_pulse_count), .chan2_pulse_count(chan2_pulse_count),
	.chan3_pulse_count(chan3_pulse_count), .chan4_pulse_count(chan4_pulse_count), .irq(irq));
`default_nettype wire

// [otl_ot_src.sv]
// Overtemp source model: drives the sensor line.
// Assumes the bench requests on mclk edges.
`timescale 1ns/1ps
`default_nettype none
module otl_ot_src (
	// Clock
	input wire logic mclk,
	// Request and line
	input wire logic hot,
	output var logic overtemp_pin
);
	// Registered, so the line never moves mid-cycle
	initial overtemp_pin = 1'b0;
	always @(posedge mclk) begin
		overtemp_pin <= hot;
	end
endmodule : otl_ot_src
`default_nettype wire

// [tb_top.sv]
// Bench: registers, pulse fields, overtemp irq.
// Assumes otl_top with a short step.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic mclk, rst, read, write, hot, irq, waitrequest, overtemp_pin;
	logic [9:0] address;
	logic [31:0] writedata, readdata, q, s;
	logic [7:0] d;
	logic [1:0] c1, c2, c3, c4;
	int fails, checks_done, n;
	otl_top #(.STEP_CYCLES(10)) DUT (.mclk(mclk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.overtemp_pin(overtemp_pin), .chan1_pulse_count(c1), .chan2_pulse_count(c2),
		.chan3_pulse_count(c3), .chan4_pulse_count(c4), .irq(irq));
	otl_ot_src src (.mclk(mclk), .hot(hot), .overtemp_pin(overtemp_pin));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] v);
		int k;
		k = 0;
		@(posedge mclk);
		write <= wr;
		read <= !wr;
		address <= {idx, 2'h0};
		writedata <= {24'h0, v};
		do begin
			@(posedge mclk);
			k++;
		end while (waitrequest !== 1'b0 && k < 40);
		if (k >= 40) fails++;
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus
	task automatic summarize;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	initial begin
		repeat (2000) @(posedge mclk);
		fails++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		{read, write, hot, address, writedata} = '0;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		bus(1'b0, 8'h7a, 8'h00);
		chk(q, 32'h0);
		bus(1'b0, 8'h7b, 8'h00);
		chk(q, 32'h55);
		chk({c4, c3, c2, c1}, 8'h55);
		bus(1'b1, 8'h10, 8'hff);
		bus(1'b0, 8'h10, 8'h00);
		chk(q, 32'h0);
		$display("reset test done");
		s = 32'hca6f;
		// Fixed words first: each word puts all four codes across the channels, one code per channel
		for (int i = 0; i < 8; i++) begin
			s = lfsr(s);
			d = (i == 0) ? 8'he4 : (i == 1) ? 8'h1b : s[7:0];
			bus(1'b1, 8'h7b, d);
			bus(1'b0, 8'h7b, 8'h00);
			chk(q, {24'h0, d});
			chk({c4, c3, c2, c1}, d);
		end
		$display("pulse test done");
		bus(1'b1, 8'h80, 8'h20);
		hot <= 1'b1;
		repeat (10) @(posedge mclk);
		chk(irq, 1'b1);
		bus(1'b0, 8'h42, 8'h00);
		chk(q[5], 1'b1);
		bus(1'b1, 8'h82, 8'h03);
		repeat (4) @(posedge mclk);
		chk(irq, 1'b0);
		bus(1'b1, 8'h82, 8'h00);
		bus(1'b1, 8'h80, 8'h00);
		repeat (4) @(posedge mclk);
		chk(irq, 1'b0);
		hot <= 1'b0;
		repeat (6) @(posedge mclk);
		hot <= 1'b1;
		bus(1'b1, 8'h7a, 8'h02);
		bus(1'b1, 8'h81, 8'hff);
		bus(1'b1, 8'h80, 8'h20);
		repeat (4) @(posedge mclk);
		bus(1'b0, 8'h79, 8'h00);
		chk(q, 32'h01);
		repeat (8) @(posedge mclk);
		chk(irq, 1'b0);
		n = 0;
		while (irq !== 1'b1 && n < 30) begin
			@(posedge mclk);
			n++;
		end
		chk(irq, 1'b1);
		$display("irq test done");
		summarize();
	end
endmodule : tb_top
`default_nettype wire
